// ---- wlsc_pkg.sv ----
// Purpose: shared constants for the wired link state control block
// Assumes: core clock of 250 MHz, link clock of 13.56 MHz made locally
// Notes:   every timing figure is kept in its own unit and turned into counts
package wlsc_pkg;

  // clock rates
  localparam int unsigned CORE_KHZ      = 250_000;
  localparam int unsigned CORE_MHZ      = 250;
  localparam int unsigned LINK_KHZ      = 13_560;
  localparam int unsigned LINK_TOL_KHZ  = 7;
  // half-period accumulator: two toggles per link period
  localparam int unsigned NCO_W         = 19;
  localparam logic [NCO_W-1:0] NCO_STEP = NCO_W'(2 * LINK_KHZ);
  localparam logic [NCO_W-1:0] NCO_WRAP = NCO_W'(CORE_KHZ);

  // off detection: both wires low at least 120 us, counted in link cycles
  localparam int unsigned OFF_LOW_US    = 120;
  localparam int unsigned OFF_LINK_CYC  = (OFF_LOW_US * LINK_KHZ + 999) / 1000;
  localparam int unsigned LOWCNT_W      = 11;
  localparam logic [LOWCNT_W-1:0] OFF_LINK_CNT = LOWCNT_W'(OFF_LINK_CYC);

  // activation timing, in core cycles
  localparam int unsigned ACT_TIMEOUT_MS = 50;
  localparam int unsigned ACT_TIMEOUT_CYC = ACT_TIMEOUT_MS * CORE_KHZ;
  localparam int unsigned WAKE_DELAY_US  = 100;
  localparam int unsigned WAKE_DELAY_CYC = WAKE_DELAY_US * CORE_MHZ;
  localparam int unsigned TMR_W          = 24;

  // wake or escape burst: pulses at 2 to 12 MHz, at least 127 of them
  localparam int unsigned BURST_MIN_MHZ  = 2;
  localparam int unsigned BURST_MAX_MHZ  = 12;
  localparam int unsigned BURST_PULSES   = 127;
  localparam int unsigned GAP_W          = 8;
  localparam logic [GAP_W-1:0] GAP_MIN   = GAP_W'(CORE_MHZ / BURST_MAX_MHZ);
  localparam logic [GAP_W-1:0] GAP_MAX   = GAP_W'((CORE_MHZ + BURST_MIN_MHZ - 1) / BURST_MIN_MHZ);
  localparam logic [GAP_W-1:0] GAP_SAT   = 8'hFF;
  localparam logic [7:0]       PULSE_NEED = 8'(BURST_PULSES);
  localparam logic [7:0]       PULSE_SAT  = 8'hFF;

  // data rates: divisors of the link clock
  localparam logic [1:0] RATE_128 = 2'h0;
  localparam logic [1:0] RATE_64  = 2'h1;
  localparam logic [1:0] RATE_32  = 2'h2;
  localparam logic [6:0] DIV_128_LAST = 7'h7F;
  localparam logic [6:0] DIV_64_LAST  = 7'h3F;
  localparam logic [6:0] DIV_32_LAST  = 7'h1F;

  // main link states
  typedef enum logic [2:0] {
    WLSC_OFF,
    WLSC_ACTIVATING,
    WLSC_ON,
    WLSC_DEACTIVATING,
    WLSC_COMMAND
  } wlsc_state_e;

endpackage : wlsc_pkg

// ---- wlsc_top.sv ----
// Purpose: radio-side link state control of a two-wire wired near field link
// Assumes: i_inbound is an asynchronous pin driven only by the far side
// Notes:   outbound wire carries a locally made 13.56 MHz clock
//          the both-low override stands back while Off
`timescale 1ns/1ns
`default_nettype none

module wlsc_top
  import wlsc_pkg::*;
#(
  parameter int unsigned ACT_TIMEOUT = wlsc_pkg::ACT_TIMEOUT_CYC,
  parameter int unsigned WAKE_DELAY  = wlsc_pkg::WAKE_DELAY_CYC
) (
  // clock and reset
  input  wire logic                  i_core_clk,
  input  wire logic                  i_sys_rst,
  // link wires
  input  wire logic                  i_inbound,
  output logic                       o_outbound,
  // user control
  input  wire logic                  i_wake,
  input  wire logic                  i_shutdown,
  input  wire logic                  i_cmd_done,
  input  wire logic [1:0]            i_rate,
  input  wire logic                  i_tx_mod,
  // status
  output wlsc_pkg::wlsc_state_e      o_state,
  output logic                       o_power_save,
  output logic                       o_inbound_level,
  output logic                       o_bit_tick
);
  import wlsc_pkg::*;

  localparam logic [TMR_W-1:0] ACT_TMO  = TMR_W'(ACT_TIMEOUT);
  localparam logic [TMR_W-1:0] WAKE_DLY = TMR_W'(WAKE_DELAY);

  // last link-clock count of a bit period for the chosen rate
  function automatic logic [6:0] rate_last(input logic [1:0] rate);
    case (rate)
      RATE_64: rate_last = DIV_64_LAST;
      RATE_32: rate_last = DIV_32_LAST;
      default: rate_last = DIV_128_LAST;
    endcase
  endfunction : rate_last

  // input synchroniser and glitch filter
  logic in_s1_q, in_s2_q, in_s3_q;
  logic in_f_q, in_f_d, in_prev_q;
  // link clock generator
  logic [NCO_W-1:0] nco_q, nco_d;
  logic             lclk_q, lclk_d;
  logic             lrise;
  // burst detector
  logic [GAP_W-1:0] gap_q, gap_d;
  logic [7:0]       pulses_q, pulses_d;
  logic             burst_done;
  // low-level timers in link cycles
  logic [LOWCNT_W-1:0] both_low_q, both_low_d;
  logic [LOWCNT_W-1:0] in_low_q, in_low_d;
  // state machine
  wlsc_state_e      state_q, state_d;
  logic [TMR_W-1:0] tmr_q, tmr_d;
  logic             clk_en_q, clk_en_d;
  logic             from_in_q, from_in_d;
  logic             dev_req_q, dev_req_d;
  // bit timing and outputs
  logic [6:0]       bit_cnt_q, bit_cnt_d;
  logic             tick_d;
  logic             out_d;
  logic             ps_d;

  // the first stage only feeds the second; filter compares later stages
  // no reset here: the stages flush within three clocks of any input
  always_ff @(posedge i_core_clk) begin
    in_s1_q <= i_inbound;
    in_s2_q <= in_s1_q;
    in_s3_q <= in_s2_q;
  end

  // a level must hold two samples (8 ns) before it is believed
  always_comb begin
    in_f_d = in_f_q;
    if (in_s2_q == in_s3_q) begin
      in_f_d = in_s3_q;
    end
  end

  // fractional accumulator: toggles average 27.12 MHz, jitter one core cycle
  // the accumulator carries a spare bit so step plus remainder never wraps
  always_comb begin
    nco_d  = nco_q + NCO_STEP;
    lclk_d = lclk_q;
    if (nco_d >= NCO_WRAP) begin
      nco_d  = nco_d - NCO_WRAP;
      lclk_d = ~lclk_q;
    end
  end
  assign lrise = lclk_d & ~lclk_q;

  // burst of pulses at 2-12 MHz followed by a steady high
  always_comb begin
    gap_d      = (gap_q == GAP_SAT) ? gap_q : gap_q + 8'h01;
    pulses_d   = pulses_q;
    burst_done = 1'b0;
    if (in_f_q && !in_prev_q) begin
      gap_d = '0;
      // the first edge of a burst has no spacing to judge
      if (pulses_q == '0 || (gap_q >= GAP_MIN && gap_q <= GAP_MAX)) begin
        pulses_d = (pulses_q == PULSE_SAT) ? pulses_q : pulses_q + 8'h01;
      end else begin
        pulses_d = 8'h01;   // spacing out of range restarts the count
      end
    end else if (gap_q > GAP_MAX && pulses_q != '0) begin
      burst_done = in_f_q && (pulses_q >= PULSE_NEED);
      pulses_d   = '0;
    end
  end

  // low timers advance on link-clock rising edges
  always_comb begin
    both_low_d = both_low_q;
    in_low_d   = in_low_q;
    // a running or starting outbound clock is not a quiet wire; taking the
    // next enable also clears a count left saturated from a long Off
    if (in_f_q || o_outbound || clk_en_d) begin
      both_low_d = '0;
    end else if (lrise && both_low_q != OFF_LINK_CNT) begin
      both_low_d = both_low_q + 11'h001;
    end
    if (in_f_q) begin
      in_low_d = '0;
    end else if (lrise && in_low_q != OFF_LINK_CNT) begin
      in_low_d = in_low_q + 11'h001;
    end
  end

  // main state machine
  always_comb begin
    state_d   = state_q;
    tmr_d     = (tmr_q == '1) ? tmr_q : tmr_q + 24'h000001;
    clk_en_d  = clk_en_q;
    from_in_d = from_in_q;
    dev_req_d = dev_req_q;
    case (state_q)
      WLSC_OFF: begin
        clk_en_d = 1'b0;
        tmr_d    = '0;
        // our own wake starts the clock at once
        if (i_wake) begin
          state_d   = WLSC_ACTIVATING;
          clk_en_d  = 1'b1;
          from_in_d = 1'b0;
        end else if (burst_done) begin
          state_d   = WLSC_ACTIVATING;
          from_in_d = 1'b1;
        end
      end
      WLSC_ACTIVATING: begin
        // a far-side wake gets no clock until the wake delay has run
        if (from_in_q) begin
          if (tmr_q >= WAKE_DLY) begin
            state_d  = WLSC_ON;
            clk_en_d = 1'b1;
          end
        end else if (in_f_q) begin
          state_d = WLSC_ON;
        end else if (tmr_q >= ACT_TMO) begin
          state_d  = WLSC_OFF;
          clk_en_d = 1'b0;
        end
      end
      WLSC_ON: begin
        tmr_d = '0;
        if (i_shutdown) begin
          state_d   = WLSC_DEACTIVATING;
          clk_en_d  = 1'b0;
          dev_req_d = 1'b1;
        end else if (in_low_q == OFF_LINK_CNT) begin
          state_d   = WLSC_DEACTIVATING;
          clk_en_d  = 1'b0;
          dev_req_d = 1'b0;
        end else if (burst_done) begin
          state_d = WLSC_COMMAND;
        end
      end
      WLSC_COMMAND: begin
        // no command set here; the user side ends the escape
        if (i_cmd_done) begin
          state_d = WLSC_ON;
        end
      end
      WLSC_DEACTIVATING: begin
        clk_en_d = 1'b0;
        // a far-side request has no answer edge of ours, so only timers end it
        if ((dev_req_q && !in_f_q) || tmr_q >= ACT_TMO) begin
          state_d = WLSC_OFF;
        end
      end
      default: begin
        state_d  = WLSC_OFF;
        clk_en_d = 1'b0;
      end
    endcase
    // both wires quiet long enough overrides every state but Off itself;
    // in Off the timer sits saturated, and letting it win there would
    // swallow every later wake request
    if (both_low_q == OFF_LINK_CNT && state_q != WLSC_OFF) begin
      state_d  = WLSC_OFF;
      clk_en_d = 1'b0;
    end
  end

  // bit period ticks and outbound drive
  always_comb begin
    bit_cnt_d = bit_cnt_q;
    tick_d    = 1'b0;
    // a rate change in mid-bit applies to the current bit; a count already past the new last ends it at the next link rise
    if (state_q != WLSC_ON) begin
      bit_cnt_d = '0;
    end else if (lrise) begin
      if (bit_cnt_q >= rate_last(i_rate)) begin
        bit_cnt_d = '0;
        tick_d    = 1'b1;
      end else begin
        bit_cnt_d = bit_cnt_q + 7'h01;
      end
    end
    // modulation only in On; idle On sends the bare clock
    out_d = clk_en_q & (lclk_d ^ (i_tx_mod & (state_q == WLSC_ON)));
    ps_d  = (state_d == WLSC_OFF);
  end

  // registers; o_state takes state_d so it always equals state_q
  // every output is a flop, so status lags its cause by one clock
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      in_f_q      <= 1'b0;
      in_prev_q   <= 1'b0;
      nco_q       <= '0;
      lclk_q      <= 1'b0;
      gap_q       <= GAP_SAT;
      pulses_q    <= '0;
      both_low_q  <= '0;
      in_low_q    <= '0;
      state_q     <= WLSC_OFF;
      tmr_q       <= '0;
      clk_en_q    <= 1'b0;
      from_in_q   <= 1'b0;
      dev_req_q   <= 1'b0;
      bit_cnt_q   <= '0;
      // outputs
      o_outbound  <= 1'b0;
      o_state     <= WLSC_OFF;
      o_power_save <= 1'b1;
      o_inbound_level <= 1'b0;
      o_bit_tick  <= 1'b0;
    end else begin
      in_f_q      <= in_f_d;
      in_prev_q   <= in_f_q;
      nco_q       <= nco_d;
      lclk_q      <= lclk_d;
      gap_q       <= gap_d;
      pulses_q    <= pulses_d;
      both_low_q  <= both_low_d;
      in_low_q    <= in_low_d;
      state_q     <= state_d;
      tmr_q       <= tmr_d;
      clk_en_q    <= clk_en_d;
      from_in_q   <= from_in_d;
      dev_req_q   <= dev_req_d;
      bit_cnt_q   <= bit_cnt_d;
      // outputs
      o_outbound  <= out_d;
      o_state     <= state_d;
      o_power_save <= ps_d;
      o_inbound_level <= in_f_q;
      o_bit_tick  <= tick_d;
    end
  end

endmodule : wlsc_top

`default_nettype wire

// ---- wlsc_assertions.sv ----
// Purpose: port checks for the link state control
// Assumes: tx modulation held low where phases are timed
// Notes:   outputs may lag the taking edge by one cycle
`timescale 1ns/1ns
`default_nettype none
module wlsc_assertions
  import wlsc_pkg::*;
(
  input wire logic                  i_core_clk,
  input wire logic                  i_sys_rst,
  input wire logic                  i_wake,
  input wire logic                  i_shutdown,
  input wire logic                  i_inbound,
  input wire logic                  i_tx_mod,
  input wire logic                  o_outbound,
  input wire logic                  o_power_save,
  input wire logic                  o_inbound_level,
  input wire wlsc_pkg::wlsc_state_e o_state
);
  logic       prev_q;
  logic       mod_q;
  logic       arm_q;
  logic       clean_q;
  logic [7:0] run_q;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  // phase length counter; the first run in On may be cut short when the
  // clock starts, and runs touched by modulation are not timed either
  always_ff @(posedge i_core_clk) begin
    prev_q  <= o_outbound;
    mod_q   <= i_tx_mod;
    run_q   <= (o_outbound != prev_q) ? 8'h00 : run_q + 8'h01;
    arm_q   <= (o_outbound != prev_q || arm_q) && o_state == WLSC_ON && !i_tx_mod && !mod_q;
    clean_q <= ((o_outbound != prev_q && arm_q) || clean_q) && o_state == WLSC_ON && !i_tx_mod && !mod_q;
  end
  reset_off_a: assert property (disable iff (1'b0) i_sys_rst |=> o_state == WLSC_OFF)
    else $error("not off after reset");
  no_jump_a: assert property (o_state == WLSC_OFF |=> o_state != WLSC_ON)
    else $error("off to on");
  on_exit_a: assert property (o_state == WLSC_ON |=> o_state != WLSC_OFF)
    else $error("on to off");
  cmd_entry_a: assert property ($changed(o_state) && o_state == WLSC_COMMAND |-> $past(o_state) == WLSC_ON)
    else $error("bad command entry");
  save_off_a: assert property ($stable(o_state) |-> o_power_save == (o_state == WLSC_OFF))
    else $error("power save wrong");
  wake_go_a: assert property (o_state == WLSC_OFF && i_wake |-> ##[1:2] o_state == WLSC_ACTIVATING)
    else $error("wake ignored");
  shut_go_a: assert property (o_state == WLSC_ON && i_shutdown |-> ##[1:2] o_state == WLSC_DEACTIVATING)
    else $error("shutdown ignored");
  deact_low_a: assert property (o_state == WLSC_DEACTIVATING && $past(o_state, 2) == o_state |-> !o_outbound)
    else $error("outbound not low");
  phase_len_a: assert property (o_outbound != prev_q && clean_q && o_state == WLSC_ON |-> run_q inside {[8'h08:8'h09]})
    else $error("clock phase length");
  level_sync_a: assert property (i_inbound [*8] |=> o_inbound_level)
    else $error("inbound level lost");
  c_on: cover property (o_state == WLSC_ACTIVATING ##1 o_state == WLSC_ON);
  c_cmd: cover property (o_state == WLSC_COMMAND);
  c_off: cover property (o_state == WLSC_DEACTIVATING ##1 o_state == WLSC_OFF);
endmodule : wlsc_assertions
`default_nettype wire

// ---- wlsc_far_end.sv ----
// Purpose: far side model driving the inbound wire
// Assumes: mode set by the bench
// Notes:   0 low, 1 high, 2 wake burst then high, 3 follow outbound
`timescale 1ns/1ns
`default_nettype none
module wlsc_far_end (
  input  wire logic       i_clk,
  input  wire logic [1:0] i_mode,
  input  wire logic       i_outbound,
  output logic            o_inbound
);
  logic [12:0] cnt_q;
  logic [1:0]  mode_q;
  logic        seen_q;
  // one counter times the burst and the silence of the outbound clock
  always_ff @(posedge i_clk) begin
    mode_q <= i_mode;
    seen_q <= i_outbound;
    if (i_mode != mode_q || i_mode == 2'h0 || (i_mode == 2'h3 && i_outbound != seen_q))
      cnt_q <= 13'h0000;
    else if (cnt_q != 13'h1FFF)
      cnt_q <= cnt_q + 13'h0001;
  end
  // we alone drive inbound; 130 pulses of 32 cycles, then high
  always_comb begin
    case (i_mode)
      2'h0: o_inbound = 1'b0;
      2'h2: o_inbound = (cnt_q < 13'h1040) ? cnt_q[4] : 1'b1;
      2'h3: o_inbound = (cnt_q < 13'h0064);
      default: o_inbound = 1'b1;
    endcase
  end
endmodule : wlsc_far_end
`default_nettype wire

// ---- wlsc_top_bench.sv ----
// Purpose: scenario bench for the link state control
// Assumes: short activation timeouts set by parameter
// Notes:   tx modulation raised for one clock only, in On
`timescale 1ns/1ns
`default_nettype none
module wlsc_top_bench;
  import wlsc_pkg::*;
  logic        i_core_clk = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic        i_wake = 1'b0;
  logic        i_shutdown = 1'b0;
  logic        i_cmd_done = 1'b0;
  logic        i_tx_mod = 1'b0;
  logic [1:0]  i_rate = 2'h0;
  logic [1:0]  mode = 2'h0;
  logic        i_inbound, o_outbound, o_power_save, o_inbound_level, o_bit_tick;
  wlsc_state_e o_state;
  int          failures = 0;
  int          checks = 0;
  wlsc_top #(.ACT_TIMEOUT(2000), .WAKE_DELAY(200)) wlsc_top_inst (.*);
  wlsc_far_end wlsc_far_end_inst (.i_clk(i_core_clk), .i_mode(mode), .i_outbound(o_outbound), .o_inbound(i_inbound));
  always #2 i_core_clk = ~i_core_clk;
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s exp %0h seen %0h", n, e, s);
    end
  endtask : chk
  // inputs move 1 ns after the edge
  task automatic step(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask : step
  task automatic wait_st(input wlsc_state_e s, input int n);
    for (int k = 0; k < n && o_state !== s; k++) step(1);
    chk("state", o_state, s);
  endtask : wait_st
  task automatic gap(output int g);
    g = 0;
    while (o_bit_tick !== 1'b1 && g < 3000) begin
      step(1);
      g++;
    end
  endtask : gap
  task automatic t_wake;
    int g;
    int e;
    logic o;
    chk("save", o_power_save, 1'b1);
    chk("state", o_state, WLSC_OFF);
    mode = 2'h3;
    i_wake = 1'b1;
    step(1);
    i_wake = 1'b0;
    wait_st(WLSC_ACTIVATING, 2);
    wait_st(WLSC_ON, 200);
    // bit period per rate, settled before timing
    for (int r = 0; r < 3; r++) begin
      i_rate = 2'(r);
      e = (128 >> r) * CORE_KHZ / LINK_KHZ;
      gap(g);
      step(1);
      gap(g);
      step(1);
      gap(g);
      chk("gap", (g + 1) inside {[e - 8:e + 8]}, 1'b1);
    end
    // modulation flips the bare clock in On; done just after a toggle,
    // since the next clock toggle is at least nine cycles away
    o = o_outbound;
    g = 0;
    while (o_outbound === o && g < 20) begin
      step(1);
      g++;
    end
    o = o_outbound;
    i_tx_mod = 1'b1;
    step(1);
    chk("mod", o_outbound, !o);
    i_tx_mod = 1'b0;
    step(1);
    chk("mod", o_outbound, o);
  endtask : t_wake
  task automatic t_shut;
    i_shutdown = 1'b1;
    wait_st(WLSC_DEACTIVATING, 3);
    i_shutdown = 1'b0;
    wait_st(WLSC_OFF, 200);
  endtask : t_shut
  task automatic t_timeout;
    mode = 2'h0;
    i_wake = 1'b1;
    step(1);
    i_wake = 1'b0;
    step(1900);
    chk("state", o_state, WLSC_ACTIVATING);
    wait_st(WLSC_OFF, 200);
  endtask : t_timeout
  task automatic t_burst;
    mode = 2'h2;
    wait_st(WLSC_ACTIVATING, 4600);
    step(180);
    chk("state", o_state, WLSC_ACTIVATING);
    chk("out", o_outbound, 1'b0);
    wait_st(WLSC_ON, 40);
    mode = 2'h1;
    step(2);
    mode = 2'h2;
    wait_st(WLSC_COMMAND, 4600);
    i_cmd_done = 1'b1;
    wait_st(WLSC_ON, 3);
    i_cmd_done = 1'b0;
  endtask : t_burst
  task automatic t_far_deact;
    mode = 2'h0;
    wait_st(WLSC_DEACTIVATING, 31000);
    wait_st(WLSC_OFF, 2100);
  endtask : t_far_deact
  task automatic report_and_stop;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  initial begin
    step(12);
    i_sys_rst = 1'b0;
    step(1);
    t_wake;
    t_shut;
    t_timeout;
    t_burst;
    t_far_deact;
    report_and_stop;
  end
  // about 55k cycles expected
  initial begin
    #(90000 * 4);
    failures++;
    report_and_stop;
  end
endmodule : wlsc_top_bench
bind wlsc_top wlsc_assertions wlsc_assertions_inst (.*);
`default_nettype wire
